// *** logic/hid_cfg.svh ***
// Purpose: constants of the host i/o initiation and done control
// Assumes: bit numbers are lsb-based (host bit 15 is index 15)
// Notes:   included by package and module; definitions only
`ifndef HID_CFG_SVH
`define HID_CFG_SVH
// ****************************************************
// device select and instruction fields
// ****************************************************
`define HID_SEL_CODE      6'h10
`define HID_DIAG_BIT      15
`define HID_MA_MSB        14
`define HID_SSC_MSB       11
`define HID_SSA_MSB       15
`define HID_SSA_LSB       12
// ****************************************************
// error register layout
// ****************************************************
`define HID_ERR_SUMMARY   15
`define HID_ERR_READCHK   14
`define HID_ERR_NODISC    13
`define HID_ERR_LATE      12
`define HID_ERR_WPROT     11
`define HID_ERR_DFAIL     10
// ****************************************************
// reset values and sizes
// ****************************************************
`define HID_WORD_RST      16'h0000
`define HID_BUF_WORDS     16
`define HID_PTR_FULL      4'hf
`endif

// *** logic/hid_pkg.sv ***
// Purpose: shared types of the host i/o initiation and done control
// Assumes: hid_cfg.svh holds the shared constants; the operation codes are set here
// Notes:   strobes arrive as one packed bundle from the i/o bus pins
`include "hid_cfg.svh"
package hid_pkg;
  // ****************************************************
  // types
  // ****************************************************
  // raw i/o bus strobes, all asynchronous to clk
  typedef struct packed {
    logic first_output_strobe;
    logic second_output_strobe;
    logic third_output_strobe;
    logic first_input_strobe;
    logic second_input_strobe;
    logic write_go_pulse;
    logic read_go_pulse;
    logic clear_strobe;
    logic bus_reset_pulse;
    logic channel_address_strobe;
    logic channel_input_strobe;
    logic channel_output_strobe;
  } hid_strobes_t;
  // formatter-side events, same clock domain
  typedef struct packed {
    logic end_flag;
    logic buffer_empty_flag;
    logic end_structure_oneshot;
    logic write_protect_err;
    logic no_disc_err;
    logic disc_fail_err;
    logic read_check_err;
    logic data_late_err;
  } hid_fmt_t;
  typedef enum logic [1:0] {
    HID_IDLE    = 2'b00,
    HID_WRITING = 2'b01,
    HID_READING = 2'b10
  } hid_op_t;
endpackage

// *** logic/hid_core.sv ***
// Purpose: host i/o select, initiation, readback and done control
// Assumes: bus pins asynchronous; formatter events on clk
// Notes:   strobe effects act on synchronised edges, 2-3 cycles late
//
// Operation
// - error register holds last operation's errors
// - status input strobes error register out
// - address input strobes address counter out
// - busy address readout returns zeros
// - channel address gate increments address counter
// - second output bit 15 selects diagnostic
// - diagnostic loops sixteen words through buffer
// - diagnostic addresses from access counter, no write
// - respond only to select code octal 20; bus reset and channel strobes act on any code
// - loads and go gated off while busy
// - go pulse initialises, clears done, starts
// - go trailing edge sets operation flag, busy
// - first output loads unit track sector
// - second output loads memory address counter
// - third output presets pending, loads count
// - clear function initialises all flags; the code leaves the diagnostic mode flag set
// - bus reset clears busy, done, pending, errors; power reset all
// - write done on end structure timeout
// - read done on final channel input fall
// - no disc, disc fail, write protect emit error end pulse
// - no disc 13+15, disc fail 10+15
// - read check 14+15, data late 12+15
// - done asserts done line, error end drops busy
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "hid_cfg.svh"
module hid_core (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [5:0]            device_select_lines,
  input  wire hid_pkg::hid_strobes_t strobes_in,
  input  wire logic [15:0]           bus_data_in,
  input  wire hid_pkg::hid_fmt_t     fmt_in,
  output logic [15:0]                bus_data_out,
  output logic                       bus_data_oe,
  output logic                       status_read_strobe,
  output logic                       address_read_strobe,
  output logic                       busy_line,
  output logic                       done_line,
  output logic                       start_pulse,
  output logic                       init_pulse,
  output logic [15:0]                unit_track_sector_q,
  output logic [3:0]                 subsector_addr_q,
  output logic [11:0]                transfer_count_q,
  output logic                       subsector_pending_flag,
  output logic                       diag_mode_q,
  output logic [3:0]                 buffer_addr,
  output logic                       buffer_write_enable,
  output logic                       error_end_pulse
);
  // ****************************************************
  // reset release and pin synchronisers
  // ****************************************************
  logic [1:0]            rst_sync_q;
  logic                  rst_n;
  hid_pkg::hid_strobes_t stb_m_q;
  hid_pkg::hid_strobes_t stb_q;
  hid_pkg::hid_strobes_t stb_prev_q;
  logic [5:0]            sel_m_q;
  logic [5:0]            sel_q;
  logic [15:0]           dat_m_q;
  logic [15:0]           dat_q;
  hid_pkg::hid_strobes_t rise;
  hid_pkg::hid_strobes_t fall;
  hid_pkg::hid_fmt_t     fmt_prev_q;

  function automatic logic [11:0] edge_of(input logic [11:0] now_v,
                                          input logic [11:0] old_v,
                                          input logic        up);
    edge_of = up ? (now_v & ~old_v) : (~now_v & old_v);
  endfunction

  // reset held asynchronously, released on clk
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_m_q    <= '0;
      stb_q      <= '0;
      stb_prev_q <= '0;
      sel_m_q    <= 6'h00;
      sel_q      <= 6'h00;
      dat_m_q    <= `HID_WORD_RST;
      dat_q      <= `HID_WORD_RST;
    end else begin
      stb_m_q    <= strobes_in;
      stb_q      <= stb_m_q;
      stb_prev_q <= stb_q;
      sel_m_q    <= device_select_lines;
      sel_q      <= sel_m_q;
      dat_m_q    <= bus_data_in;
      dat_q      <= dat_m_q;
    end
  end

  // edges from the second stage only
  assign rise = hid_pkg::hid_strobes_t'(edge_of(stb_q, stb_prev_q, 1'b1));
  assign fall = hid_pkg::hid_strobes_t'(edge_of(stb_q, stb_prev_q, 1'b0));

  // ****************************************************
  // selection and gating
  // ****************************************************
  hid_pkg::hid_op_t op_q;
  logic             selected;
  logic             idle_gate;
  logic             init_any;
  logic             done_set;
  logic             done_q;
  logic             pending_q;
  logic             go_any_rise;
  logic             err_hit;

  assign selected  = (sel_q == `HID_SEL_CODE);
  // loads and go only while not busy
  assign idle_gate = selected && (op_q == hid_pkg::HID_IDLE);
  assign go_any_rise = idle_gate && (rise.write_go_pulse ||
                                     rise.read_go_pulse);
  assign init_any  = go_any_rise || (selected && rise.clear_strobe) ||
                     rise.bus_reset_pulse;
  assign init_pulse  = init_any;
  assign start_pulse = go_any_rise;

  // ****************************************************
  // operation flags
  // ****************************************************
  // done wins over a go trailing edge seen the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= hid_pkg::HID_IDLE;
    end else if ((selected && rise.clear_strobe) ||
                 rise.bus_reset_pulse || done_set) begin
      op_q <= hid_pkg::HID_IDLE;
    end else if (idle_gate && fall.write_go_pulse) begin
      op_q <= hid_pkg::HID_WRITING;
    end else if (idle_gate && fall.read_go_pulse) begin
      op_q <= hid_pkg::HID_READING;
    end
  end
  assign busy_line = (op_q != hid_pkg::HID_IDLE);

  // ****************************************************
  // done control
  // ****************************************************
  logic wr_done;
  logic rd_done;
  logic diag_full;

  assign wr_done = (op_q == hid_pkg::HID_WRITING) && fmt_in.end_flag &&
                   fmt_in.buffer_empty_flag &&
                   fmt_prev_q.end_structure_oneshot &&
                   !fmt_in.end_structure_oneshot;
  // read end on final input strobe fall
  assign rd_done = (op_q == hid_pkg::HID_READING) && fmt_in.end_flag &&
                   fall.channel_input_strobe;
  assign done_set = wr_done || rd_done || err_hit || diag_full;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (init_any) begin
      done_q <= 1'b0;
    end
  end
  assign done_line = done_q;

  // ****************************************************
  // error register and error end
  // ****************************************************
  logic [15:0] err_q;
  logic        end_err_rise;

  // rising edge of a terminating error while busy
  assign end_err_rise = busy_line &&
    ((fmt_in.write_protect_err && !fmt_prev_q.write_protect_err) ||
     (fmt_in.no_disc_err && !fmt_prev_q.no_disc_err) ||
     (fmt_in.disc_fail_err && !fmt_prev_q.disc_fail_err));
  assign err_hit = end_err_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_prev_q      <= '0;
      error_end_pulse <= 1'b0;
    end else begin
      fmt_prev_q      <= fmt_in;
      error_end_pulse <= end_err_rise;
    end
  end

  // errors held until next go, clear or bus reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= `HID_WORD_RST;
    end else begin
      if (init_any) begin
        err_q <= `HID_WORD_RST;
      end
      // no disc, disc fail, write protect, read check and late bits
      if (fmt_in.no_disc_err) begin
        err_q[`HID_ERR_NODISC]  <= 1'b1;
        err_q[`HID_ERR_SUMMARY] <= 1'b1;
      end
      if (fmt_in.disc_fail_err) begin
        err_q[`HID_ERR_DFAIL]   <= 1'b1;
        err_q[`HID_ERR_SUMMARY] <= 1'b1;
      end
      if (fmt_in.write_protect_err) begin
        err_q[`HID_ERR_WPROT]   <= 1'b1;
        err_q[`HID_ERR_SUMMARY] <= 1'b1;
      end
      if (fmt_in.read_check_err) begin
        err_q[`HID_ERR_READCHK] <= 1'b1;
        err_q[`HID_ERR_SUMMARY] <= 1'b1;
      end
      if (fmt_in.data_late_err) begin
        err_q[`HID_ERR_LATE]    <= 1'b1;
        err_q[`HID_ERR_SUMMARY] <= 1'b1;
      end
    end
  end

  // ****************************************************
  // address, sector and count registers
  // ****************************************************
  logic [`HID_MA_MSB:0] mem_addr_q;
  logic [3:0]           ssa_stage_q;

  // unit track sector from first output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_track_sector_q <= `HID_WORD_RST;
    end else if (idle_gate && rise.first_output_strobe) begin
      unit_track_sector_q <= dat_q;
    end
  end

  // counter load wins over a gate pulse, never both while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_q  <= '0;
      diag_mode_q <= 1'b0;
    end else if (idle_gate && rise.second_output_strobe) begin
      mem_addr_q  <= dat_q[`HID_MA_MSB:0];
      diag_mode_q <= dat_q[`HID_DIAG_BIT];
    end else if (busy_line && rise.channel_address_strobe) begin
      mem_addr_q <= mem_addr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q        <= 1'b0;
      transfer_count_q <= 12'h000;
      ssa_stage_q      <= 4'h0;
    end else if (idle_gate && rise.third_output_strobe) begin
      pending_q        <= 1'b1;
      transfer_count_q <= dat_q[`HID_SSC_MSB:0];
      ssa_stage_q      <= dat_q[`HID_SSA_MSB:`HID_SSA_LSB];
    end else if (init_any && !go_any_rise) begin
      pending_q <= 1'b0;
    end else if (busy_line && rise.channel_address_strobe &&
                 transfer_count_q != 12'h000) begin
      transfer_count_q <= transfer_count_q - 1'b1;
    end
  end
  assign subsector_pending_flag = pending_q;

  // address taken when pending and start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subsector_addr_q <= 4'h0;
    end else if (pending_q && go_any_rise) begin
      subsector_addr_q <= ssa_stage_q;
    end
  end

  // ****************************************************
  // diagnostic buffer loopback
  // ****************************************************
  logic [15:0] buf_mem [0:`HID_BUF_WORDS-1];
  logic [3:0]  proc_ptr_q;
  logic        diag_wr;
  logic        diag_rd;

  // channel words into and out of buffer
  assign diag_wr = diag_mode_q && (op_q == hid_pkg::HID_WRITING) &&
                   rise.channel_output_strobe;
  assign diag_rd = diag_mode_q && (op_q == hid_pkg::HID_READING) &&
                   rise.channel_input_strobe;
  assign diag_full = diag_wr && (proc_ptr_q == `HID_PTR_FULL);
  // access counter addresses, readback never writes
  assign buffer_addr         = proc_ptr_q;
  assign buffer_write_enable = diag_wr;

  always_ff @(posedge clk) begin
    if (diag_wr) begin
      buf_mem[proc_ptr_q] <= dat_q;
    end
  end

  // pointer restarts at each go so both passes span 16 words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_ptr_q <= 4'h0;
    end else if (init_any) begin
      proc_ptr_q <= 4'h0;
    end else if (diag_wr || diag_rd) begin
      proc_ptr_q <= proc_ptr_q + 1'b1;
    end
  end

  // ****************************************************
  // data bus readback
  // ****************************************************
  // output stands while the synced input strobe is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_out <= `HID_WORD_RST;
      bus_data_oe  <= 1'b0;
    end else if (selected && stb_q.first_input_strobe) begin
      bus_data_out <= err_q;
      bus_data_oe  <= 1'b1;
    end else if (selected && stb_q.second_input_strobe) begin
      bus_data_out <= busy_line ? `HID_WORD_RST :
                      {1'b0, mem_addr_q};
      bus_data_oe  <= 1'b1;
    end else if (diag_rd) begin
      // buffered word back to the host
      bus_data_out <= buf_mem[proc_ptr_q];
      bus_data_oe  <= 1'b1;
    end else if (!stb_q.channel_input_strobe) begin
      bus_data_oe  <= 1'b0;
    end
  end
  assign status_read_strobe  = selected && stb_q.first_input_strobe;
  // address strobe gated off while busy
  assign address_read_strobe = idle_gate && stb_q.second_input_strobe;

  // ****************************************************
  // checks
  // ****************************************************
  property p_sel_only;
    @(posedge clk) disable iff (!rst_n)
      (sel_q != `HID_SEL_CODE) |-> !status_read_strobe && !start_pulse;
  endproperty
  a_sel_only: assert property (p_sel_only)
    else $error("strobe while not selected");

  property p_busy_gate;
    @(posedge clk) disable iff (!rst_n)
      busy_line && rise.second_output_strobe && !done_set
      |=> $stable(mem_addr_q) || $past(rise.channel_address_strobe);
  endproperty
  a_busy_gate: assert property (p_busy_gate)
    else $error("address load taken while busy");

  property p_go_clears_done;
    @(posedge clk) disable iff (!rst_n)
      start_pulse && !done_set |=> !done_line;
  endproperty
  a_go_clears_done: assert property (p_go_clears_done)
    else $error("go did not clear done");

  property p_trailing_busy;
    @(posedge clk) disable iff (!rst_n)
      idle_gate && fall.read_go_pulse && !rise.clear_strobe &&
      !rise.bus_reset_pulse && !done_set |=> busy_line;
  endproperty
  a_trailing_busy: assert property (p_trailing_busy)
    else $error("busy not raised on go trailing edge");

  property p_zero_when_busy;
    @(posedge clk) disable iff (!rst_n)
      selected && stb_q.second_input_strobe && busy_line &&
      !stb_q.first_input_strobe |=> bus_data_out == 16'h0000;
  endproperty
  a_zero_when_busy: assert property (p_zero_when_busy)
    else $error("address shown while busy");

  property p_addr_step;
    @(posedge clk) disable iff (!rst_n)
      busy_line && rise.channel_address_strobe
      |=> mem_addr_q == $past(mem_addr_q) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address counter did not step");

  property p_clear_all;
    @(posedge clk) disable iff (!rst_n)
      selected && rise.clear_strobe && !done_set
      |=> !busy_line && !done_line && !subsector_pending_flag;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clear left a flag set");

  property p_err_end;
    @(posedge clk) disable iff (!rst_n)
      end_err_rise |=> done_line && !busy_line && error_end_pulse;
  endproperty
  a_err_end: assert property (p_err_end)
    else $error("error end did not finish operation");

  property p_late_bits;
    @(posedge clk) disable iff (!rst_n)
      fmt_in.data_late_err |=> err_q[12] && err_q[15];
  endproperty
  a_late_bits: assert property (p_late_bits)
    else $error("late error bits missing");

  property p_diag_no_write;
    @(posedge clk) disable iff (!rst_n)
      op_q == hid_pkg::HID_READING |-> !buffer_write_enable;
  endproperty
  a_diag_no_write: assert property (p_diag_no_write)
    else $error("buffer written during readback");
endmodule

// *** tb/hid_cpu_model.sv ***
// Purpose: processor side of the parallel i/o bus
// Assumes: pins change after a rising edge and stand 4 cycles
// Notes:   data pins show the inverse word once released
`timescale 1ns/10ps
module hid_cpu_model (
  input  wire logic             clk,
  output hid_pkg::hid_strobes_t strobes,
  output logic [5:0]            select_code,
  output logic [15:0]           data_to_dev,
  input  wire logic [15:0]      data_from_dev,
  input  wire logic             status_read_strobe,
  input  wire logic             address_read_strobe
);
  // ****************************************************
  // idle bus
  // ****************************************************
  // select code
  initial begin
    select_code = 6'h10;
    strobes     = '0;
    data_to_dev = 16'h0000;
  end
  // select code changes only here, one driver for the pins
  task automatic select(input logic [5:0] c);
    @(posedge clk);
    select_code <= c;
  endtask
  // one instruction: strobe high 4 cycles, low 4 cycles
  // word and function
  task automatic io(input logic [11:0] m, input logic [15:0] d,
                    output logic [15:0] r, output logic [1:0] f);
    @(posedge clk);
    strobes     <= m;
    data_to_dev <= d;
    repeat (4) @(posedge clk);
    r = data_from_dev;
    f = {status_read_strobe, address_read_strobe};
    strobes <= '0;
    repeat (4) @(posedge clk);
    data_to_dev <= ~d; // no stale word after release
    #1;
  endtask
endmodule

// *** tb/host_io_initiation_done_control_test.sv ***
// Purpose: scenarios for the host i/o initiation and done control
// Assumes: processor model drives pins; bench drives formatter events
// Notes:   outputs sampled 1 ns after an edge to avoid races
`timescale 1ns/10ps
`include "hid_cfg.svh"
module host_io_initiation_done_control_test;
  localparam logic [11:0] S_OUT1 = 12'h800, S_OUT2 = 12'h400;
  localparam logic [11:0] S_OUT3 = 12'h200, S_IN1 = 12'h100;
  localparam logic [11:0] S_IN2 = 12'h080, S_WGO = 12'h040;
  localparam logic [11:0] S_RGO = 12'h020, S_CLR = 12'h010;
  localparam logic [11:0] S_RST = 12'h008, S_CHA = 12'h004;
  localparam logic [11:0] S_CHI = 12'h002, S_CHO = 12'h001;
  logic                  clk, reset_n, oe, stat, adr, busy, done;
  logic                  start, init, pend, diag, bwe, eep, reading;
  logic [5:0]            sel;
  hid_pkg::hid_strobes_t strb;
  hid_pkg::hid_fmt_t     fmt;
  logic [15:0]           din, dout, uts, rd;
  logic [3:0]            ssa, baddr;
  logic [11:0]           tcnt;
  logic [1:0]            fl;
  int                    fails, n_tests, n_start, n_eep, n_bwe, n_init;
  hid_core uut (.clk(clk), .reset_n(reset_n), .device_select_lines(sel),
    .strobes_in(strb), .bus_data_in(din), .fmt_in(fmt),
    .bus_data_out(dout), .bus_data_oe(oe), .status_read_strobe(stat),
    .address_read_strobe(adr), .busy_line(busy), .done_line(done),
    .start_pulse(start), .init_pulse(init), .unit_track_sector_q(uts),
    .subsector_addr_q(ssa), .transfer_count_q(tcnt),
    .subsector_pending_flag(pend), .diag_mode_q(diag),
    .buffer_addr(baddr), .buffer_write_enable(bwe),
    .error_end_pulse(eep));
  hid_cpu_model cpu (.clk(clk), .strobes(strb), .select_code(sel),
    .data_to_dev(din), .data_from_dev(dout), .status_read_strobe(stat),
    .address_read_strobe(adr));
  // ****************************************************
  // clock and pulse counters
  // ****************************************************
  always #25 clk = ~clk;
  // one-cycle pulses are counted, never sampled late
  always @(posedge clk) begin
    if (start === 1'b1) n_start++;
    if (init === 1'b1) n_init++;
    if (eep === 1'b1) n_eep++;
    if (reading && bwe === 1'b1) n_bwe++;
  end
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask
  task automatic op(logic [11:0] m, logic [15:0] d);
    cpu.io(m, d, rd, fl);
  endtask
  task automatic set_fmt(logic [7:0] v);
    @(posedge clk);
    fmt <= v;
    #1; // let the edge's pulse counters settle first
  endtask
  task automatic wait_done;
    for (int i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      fails++;
      close_out;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_write;
    int n0;
    op(S_OUT1, 16'h1234);
    check("uts", uts, 16'h1234);
    op(S_OUT2, 16'h0100);
    op(S_OUT3, 16'ha005);
    check("count", 16'(tcnt), 16'h0005);
    check("pending", 16'(pend), 16'h0001);
    n0 = n_start;
    op(S_WGO, 16'h0000);
    check("starts", 16'(n_start - n0), 16'h0001);
    check("busy", 16'(busy), 16'h0001);
    check("ssa", 16'(ssa), 16'h000a);
    op(S_OUT1, 16'hffff);
    op(S_OUT2, 16'h7fff); // refused while busy
    check("uts busy", uts, 16'h1234);
    op(S_IN2, 16'h0000);
    check("addr busy", rd, 16'h0000);
    check("addr strobe", 16'(fl[0]), 16'h0000);
    repeat (3) op(S_CHA, 16'h0000);
    set_fmt(8'he0);
    set_fmt(8'hc0);
    wait_done;
    check("busy end", 16'(busy), 16'h0000);
    set_fmt(8'h00);
    op(S_IN2, 16'h0000);
    check("addr", rd, 16'h0103);
    check("addr strobe idle", 16'(fl[0]), 16'h0001);
  endtask
  task automatic t_read;
    op(S_RGO, 16'h0000);
    check("done go", 16'(done), 16'h0000);
    set_fmt(8'h80);
    op(S_CHI, 16'h0000);
    check("done read", 16'(done), 16'h0001);
    check("busy read", 16'(busy), 16'h0000);
    set_fmt(8'h00);
  endtask
  task automatic t_errors;
    logic [7:0] ev [3] = '{8'h10, 8'h08, 8'h04};
    int         bt [3] = '{`HID_ERR_WPROT, `HID_ERR_NODISC, `HID_ERR_DFAIL};
    int         n0;
    for (int k = 0; k < 3; k++) begin
      op(S_WGO, 16'h0000);
      n0 = n_eep;
      set_fmt(ev[k]);
      wait_done;
      set_fmt(8'h00);
      check("err end", 16'(n_eep - n0), 16'h0001);
      check("busy err", 16'(busy), 16'h0000);
      op(S_IN1, 16'h0000);
      check("stat strobe", 16'(fl[1]), 16'h0001);
      check("err bit", 16'(rd[bt[k]]), 16'h0001);
      op(S_IN1, 16'h0000);
      check("err kept", 16'(rd[bt[k]]), 16'h0001);
    end
    check("summary", 16'(rd[`HID_ERR_SUMMARY]), 16'h0001);
    op(S_RGO, 16'h0000);
    set_fmt(8'h03);
    set_fmt(8'h00);
    op(S_IN1, 16'h0000);
    check("late chk", {rd[`HID_ERR_SUMMARY], rd[`HID_ERR_READCHK],
      rd[`HID_ERR_LATE], busy}, 16'h000f);
  endtask
  task automatic t_clear;
    int n0;
    n0 = n_init;
    op(S_CLR, 16'h0000);
    check("busy clr", 16'({busy, done}), 16'h0000);
    check("init clr", 16'(n_init - n0), 16'h0001);
    op(S_OUT3, 16'h0001);
    op(S_CLR, 16'h0000);
    check("pend clr", 16'(pend), 16'h0000);
  endtask
  task automatic t_select;
    cpu.select(6'h11);
    op(S_OUT1, 16'h5555);
    check("uts unsel", uts, 16'h1234);
    op(S_IN1, 16'h0000);
    check("stat unsel", 16'(fl[1]), 16'h0000);
    cpu.select(6'h10);
    op(S_OUT1, 16'h5555);
    check("uts sel", uts, 16'h5555);
  endtask
  task automatic t_diag;
    op(S_OUT2, 16'h8000);
    check("diag", 16'(diag), 16'h0001);
    op(S_WGO, 16'h0000);
    for (int i = 0; i < `HID_BUF_WORDS; i++)
      op(S_CHO, {i[3:0], ~i[3:0], i[3:0], 4'ha});
    wait_done;
    check("diag full", 16'(busy), 16'h0000);
    reading = 1'b1;
    op(S_RGO, 16'h0000);
    for (int i = 0; i < `HID_BUF_WORDS; i++) begin
      check("buf addr", 16'(baddr), 16'(i[3:0]));
      op(S_CHI, 16'h0000);
      check("loop word", rd, {i[3:0], ~i[3:0], i[3:0], 4'ha});
    end
    reading = 1'b0;
    check("no write", 16'(n_bwe), 16'h0000);
    op(S_CLR, 16'h0000);
    op(S_OUT2, 16'h0000);
    check("diag off", 16'(diag), 16'h0000);
  endtask
  task automatic t_bus_reset;
    op(S_WGO, 16'h0000);
    cpu.select(6'h11);
    op(S_RST, 16'h0000);
    check("busy rst", 16'({busy, done, diag}), 16'h0000);
    cpu.select(6'h10);
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    clk     = 1'b0;
    reset_n = 1'b0;
    fmt     = '0;
    reading = 1'b0;
    fails   = 0;
    n_tests = 0;
    n_start = 0;
    n_eep   = 0;
    n_bwe   = 0;
    n_init  = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("idle", 16'({busy, done, oe}), 16'h0000);
    t_write;
    t_read;
    t_errors;
    t_clear;
    t_select;
    t_diag;
    t_bus_reset;
    close_out;
  end
endmodule
